/* File: rtl/mma_dev.sv */
// Multiply-accumulate device end: operand, result and sum-extension
// registers on the peripheral word bus, plus a two-stage datapath.
// Assumes a single-cycle wr or rd strobe from the host on pclk.
//
// Contract
// - Four first-operand addresses each select one mode
// - First-operand write stores operand and mode only
// - Second-operand write starts operation, updates all results
// - Result valid three cycles after second operand
// - First operand and mode kept across operations
// - Any mix of byte and word operands
// - Low result holds result bits 15 to 0
// - High result holds upper bits, signed or not
// - Unsigned: extension zero, or carry in accumulate
// - Signed: extension all ones when result negative
// - Signed accumulate wraps, never saturates
// - Overflow reads ones, underflow zero; software checks
// - Pointer reads wait one instruction after start
// - Host keeps mode-to-start sequence uninterrupted
// - Host sign-extends byte operands for signed modes
// - Word registers at consecutive even addresses
//
// Decided for this implementation: the APB slave port.
`include "mma_consts.svh"

module mma_dev (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Peripheral bus
  mma_if.dev bus,
  // User-side status
  output mma_pkg::mma_mode_t mode_q,
  output logic busy_q,
  output logic done_q,
  output logic [31:0] result_q,
  output logic [15:0] sum_extension_q
);
  import mma_pkg::*;

  logic [15:0] op1_q;
  logic [15:0] op2_q;
  logic start_q;
  logic prod_v_q;
  logic [31:0] prod_q;
  mma_mode_t pmode_q;
  logic [15:0] rdata_q;
  logic rvalid_q;

  function automatic logic is_op1(input logic [15:0] a);
    return (a >= `MMA_A_OP1_UMUL) && (a <= `MMA_A_OP1_SACC) && !a[0];
  endfunction

  // Address decode
  wire logic wr_op1;
  wire logic wr_op2;
  wire logic wr_lo;
  wire logic wr_hi;
  wire logic [15:0] wr_word;
  wire mma_mode_t addr_mode;

  assign wr_op1 = bus.wr && is_op1(bus.addr);
  assign wr_op2 = bus.wr && (bus.addr == `MMA_A_OP2);
  assign wr_lo = bus.wr && (bus.addr == `MMA_A_RES_LO);
  assign wr_hi = bus.wr && (bus.addr == `MMA_A_RES_HI);
  assign addr_mode =
    mma_mode_t'(bus.addr[`MMA_MODE_MSB:`MMA_MODE_LSB]);
  // Byte writes clear the upper half
  assign wr_word = bus.byte_w ? {8'h00, bus.wdata[7:0]} : bus.wdata;

  // Operand extension and the shared multiplier
  wire logic op_signed;
  wire logic [31:0] ext1;
  wire logic [31:0] ext2;
  wire logic [31:0] product;

  assign op_signed = mode_q[0];
  assign ext1 = op_signed ? {{16{op1_q[15]}}, op1_q} : {16'h0000, op1_q};
  assign ext2 = op_signed ? {{16{op2_q[15]}}, op2_q} : {16'h0000, op2_q};
  // Low 32 bits of a 32x32 product equal the signed 16x16 product
  assign product = ext1 * ext2;

  // Accumulate and sum-extension selection
  wire logic [32:0] acc_sum;
  wire logic acc;
  wire logic [31:0] new_res;
  wire logic [15:0] new_ext;

  assign acc = pmode_q[1];
  assign acc_sum = {1'b0, result_q} + {1'b0, prod_q};
  // Plain 32-bit wrap: no saturation in signed accumulate
  assign new_res = acc ? acc_sum[31:0] : prod_q;
  assign new_ext =
    (pmode_q == MMA_UMUL) ? `MMA_SUM_EXTENSION_ZERO :
    (pmode_q == MMA_UACC) ?
      (acc_sum[32] ? `MMA_SUM_EXTENSION_CARRY : `MMA_SUM_EXTENSION_ZERO) :
    (new_res[31] ? `MMA_SUM_EXTENSION_NEG : `MMA_SUM_EXTENSION_ZERO);

  // Read decode
  wire logic [15:0] rd_word;

  assign rd_word =
    is_op1(bus.addr) ? op1_q :
    (bus.addr == `MMA_A_OP2) ? op2_q :
    (bus.addr == `MMA_A_RES_LO) ? result_q[15:0] :
    (bus.addr == `MMA_A_RES_HI) ? result_q[31:16] :
    (bus.addr == `MMA_A_SUM_EXTENSION) ? sum_extension_q :
    `MMA_RST_WORD;

  assign bus.rdata = rdata_q;
  assign bus.rvalid = rvalid_q;

  // Operands and mode; no start on a first-operand write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op1_q <= `MMA_RST_WORD;
      mode_q <= MMA_UMUL;
    end else if (wr_op1) begin
      op1_q <= wr_word;
      mode_q <= addr_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op2_q <= `MMA_RST_WORD;
    end else if (wr_op2) begin
      op2_q <= wr_word;
    end
  end

  // Stage 1: product of the stored operands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      prod_v_q <= 1'b0;
      prod_q <= 32'h00000000;
      pmode_q <= MMA_UMUL;
    end else begin
      start_q <= wr_op2;
      prod_v_q <= start_q;
      if (start_q) begin
        prod_q <= product;
        pmode_q <= mode_q;
      end
    end
  end

  // Stage 2: results written; pipeline update wins over software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 32'h00000000;
      sum_extension_q <= `MMA_SUM_EXTENSION_ZERO;
    end else if (prod_v_q) begin
      result_q <= new_res;
      sum_extension_q <= new_ext;
    end else begin
      if (wr_lo) begin
        result_q[15:0] <= wr_word;
      end
      if (wr_hi) begin
        result_q[31:16] <= wr_word;
      end
    end
  end

  // Busy from start until results land, done in the cycle they land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= wr_op2 || start_q;
      done_q <= prod_v_q;
    end
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= `MMA_RST_WORD;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.rd;
      if (bus.rd) begin
        rdata_q <= rd_word;
      end
    end
  end

endmodule

/* File: rtl/mma_consts.svh */
// Offsets, field positions and timing counts of the multiply-accumulate
// block. Included by the package and both ends; definitions only.
`ifndef MMA_CONSTS_SVH
`define MMA_CONSTS_SVH

// Peripheral bus word addresses of the device
`define MMA_A_OP1_UMUL 16'h0130
`define MMA_A_OP1_SMUL 16'h0132
`define MMA_A_OP1_UACC 16'h0134
`define MMA_A_OP1_SACC 16'h0136
`define MMA_A_OP2 16'h0138
`define MMA_A_RES_LO 16'h013A
`define MMA_A_RES_HI 16'h013C
`define MMA_A_SUM_EXTENSION 16'h013E

// Mode field taken from the first-operand address
`define MMA_MODE_LSB 1
`define MMA_MODE_MSB 2

// Sum-extension values
`define MMA_SUM_EXTENSION_ZERO 16'h0000
`define MMA_SUM_EXTENSION_CARRY 16'h0001
`define MMA_SUM_EXTENSION_NEG 16'hFFFF

// Reset values
`define MMA_RST_WORD 16'h0000

// Host APB register byte offsets
`define MMA_APB_ADDR 8'h00
`define MMA_APB_WDATA 8'h04
`define MMA_APB_CTRL 8'h08
`define MMA_APB_STAT 8'h0C
`define MMA_APB_RDATA 8'h10

// Host control fields
`define MMA_CTRL_WRITE 0
`define MMA_CTRL_BYTE 1
`define MMA_STAT_BUSY 0

// Result latency in clock cycles, and host wait after a start
`define MMA_RES_CYC 3
`define MMA_GAP_CYC 2'h2

`endif

/* File: rtl/mma_pkg.sv */
// Types shared by both ends of the multiply-accumulate block.
// Assumes mma_consts.svh on the include path.
`include "mma_consts.svh"

package mma_pkg;

  // Bit 0 signed, bit 1 accumulate
  typedef enum logic [1:0] {
    MMA_UMUL = 2'h0,
    MMA_SMUL = 2'h1,
    MMA_UACC = 2'h2,
    MMA_SACC = 2'h3
  } mma_mode_t;

  typedef enum logic [1:0] {
    MMA_IDLE = 2'h0,
    MMA_ISSUE = 2'h1,
    MMA_WAIT = 2'h3,
    MMA_GAP = 2'h2
  } mma_hstate_t;

endpackage

/* File: rtl/mma_if.sv */
// Peripheral word bus between the host controller and the
// multiply-accumulate device. Single clock, no clocking block.
interface mma_if;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic byte_w;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic rvalid;

  modport dev (
    input addr, wdata, byte_w, wr, rd,
    output rdata, rvalid
  );

  modport host (
    output addr, wdata, byte_w, wr, rd,
    input rdata, rvalid
  );
endinterface

/* File: rtl/mma_host.sv */
// Host end: APB slave whose commands become single accesses on the
// multiply-accumulate word bus. Assumes a standard APB master on pclk.
`include "mma_consts.svh"

module mma_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Device bus
  mma_if.host bus,
  // Status
  output mma_pkg::mma_hstate_t state_q
);
  import mma_pkg::*;

  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] baddr_q;
  logic [15:0] bwdata_q;
  logic bbyte_q;
  logic wr_q;
  logic rd_q;
  logic [15:0] rdata_q;
  logic [1:0] gap_q;

  wire logic setup;
  wire logic commit;
  wire logic hit;
  wire logic launch;
  wire logic busy;
  wire logic [31:0] rd_mux;

  assign setup = psel && !penable && !pready_q;
  assign commit = psel && penable && pready_q && pwrite;
  assign hit = (paddr == `MMA_APB_ADDR) || (paddr == `MMA_APB_WDATA) ||
    (paddr == `MMA_APB_CTRL) || (paddr == `MMA_APB_STAT) ||
    (paddr == `MMA_APB_RDATA);
  assign busy = (state_q != MMA_IDLE);
  // One access at a time; a launch while busy is dropped
  assign launch = commit && (paddr == `MMA_APB_CTRL) && !busy;
  assign rd_mux =
    (paddr == `MMA_APB_ADDR) ? {16'h0000, addr_q} :
    (paddr == `MMA_APB_WDATA) ? {16'h0000, wdata_q} :
    (paddr == `MMA_APB_STAT) ? {31'h00000000, busy} :
    (paddr == `MMA_APB_RDATA) ? {16'h0000, rdata_q} :
    32'h00000000;

  assign bus.addr = baddr_q;
  assign bus.wdata = bwdata_q;
  assign bus.byte_w = bbyte_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !hit;
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= `MMA_RST_WORD;
      wdata_q <= `MMA_RST_WORD;
    end else if (commit) begin
      if (paddr == `MMA_APB_ADDR) begin
        addr_q <= pwdata[15:0];
      end
      if (paddr == `MMA_APB_WDATA) begin
        wdata_q <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MMA_IDLE;
      baddr_q <= `MMA_RST_WORD;
      bwdata_q <= `MMA_RST_WORD;
      bbyte_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdata_q <= `MMA_RST_WORD;
      gap_q <= 2'h0;
    end else begin
      unique case (state_q)
        MMA_IDLE: begin
          if (launch) begin
            baddr_q <= addr_q;
            bwdata_q <= wdata_q;
            bbyte_q <= pwdata[`MMA_CTRL_BYTE];
            wr_q <= pwdata[`MMA_CTRL_WRITE];
            rd_q <= !pwdata[`MMA_CTRL_WRITE];
            state_q <= MMA_ISSUE;
          end
        end
        MMA_ISSUE: begin
          wr_q <= 1'b0;
          rd_q <= 1'b0;
          gap_q <= `MMA_GAP_CYC;
          if (rd_q) begin
            state_q <= MMA_WAIT;
          end else if (baddr_q == `MMA_A_OP2) begin
            state_q <= MMA_GAP;
          end else begin
            state_q <= MMA_IDLE;
          end
        end
        MMA_WAIT: begin
          if (bus.rvalid) begin
            rdata_q <= bus.rdata;
            state_q <= MMA_IDLE;
          end
        end
        MMA_GAP: begin
          // Hold off reads until the result has landed
          gap_q <= gap_q - 2'h1;
          if (gap_q == 2'h1) begin
            state_q <= MMA_IDLE;
          end
        end
      endcase
    end
  end

endmodule

/* File: sim/mma_chk.sv */
// Checker on the word bus and device status of the multiply block.
// Assumes the testbench wires it beside the shared interface.
`include "mma_consts.svh"
module mma_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Word bus
  input wire logic [15:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  // Device status
  input wire mma_pkg::mma_mode_t mode_q,
  input wire logic busy_q,
  input wire logic done_q,
  input wire logic [31:0] result_q,
  input wire logic [15:0] sum_extension_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import mma_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire op2_wr = wr && addr == `MMA_A_OP2;
  wire op1_wr = wr && addr[15:3] == 13'h026;
  wire res_wr = wr && (addr == `MMA_A_RES_LO || addr == `MMA_A_RES_HI);
  a_read_answer: assert property (rd |=> rvalid)
    else $error("read not answered next cycle");
  a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved without a read");
  a_mode_latch: assert property (op1_wr |=> mode_q == $past(addr[2:1]))
    else $error("mode not taken from operand address");
  a_op1_quiet: assert property (op1_wr |=> !busy_q ##1 !busy_q)
    else $error("first operand started an operation");
  a_start_seq: assert property (
    op2_wr |=> busy_q [*2] ##1 (done_q && !busy_q))
    else $error("start sequence wrong");
  a_result_cause: assert property ($changed(result_q) |->
    $past(op2_wr, 3) || $past(res_wr))
    else $error("result changed without cause");
  a_umul_ext: assert property (
    done_q && mode_q == MMA_UMUL |-> sum_extension_q == `MMA_SUM_EXTENSION_ZERO)
    else $error("unsigned product extension not zero");
  a_sign_ext: assert property (
    done_q && mode_q[0] |-> sum_extension_q == {16{result_q[31]}})
    else $error("signed extension wrong");
  cover property (done_q && mode_q == MMA_SACC);
  cover property (done_q && mode_q == MMA_UACC && sum_extension_q[0]);
  cover property (rvalid);
endmodule

/* File: sim/tb_memory_mapped_multiply_accumulate.sv */
// Testbench: an APB master works the host end, which drives the device.
// Assumes both design ends, the interface and the checker compiled.
`include "mma_consts.svh"
module tb_memory_mapped_multiply_accumulate;
  timeunit 1ns;
  timeprecision 1ps;
  import mma_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q, result_q, acc, rv;
  logic pready_q, pslverr_q, busy_q, done_q, perr;
  mma_hstate_t state_q;
  mma_mode_t mode_q;
  logic [15:0] sum_extension_q, o1, ex;
  logic [1:0] md;
  int err_count = 0;
  int total_checks = 0;
  always #4 pclk = ~pclk;
  mma_if bus ();
  mma_host mma_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .bus(bus.host), .state_q(state_q));
  mma_dev mma_dev_inst (.pclk(pclk), .presetn(presetn), .bus(bus.dev),
    .mode_q(mode_q), .busy_q(busy_q), .done_q(done_q),
    .result_q(result_q), .sum_extension_q(sum_extension_q));
  mma_chk mma_chk_inst (.pclk(pclk), .presetn(presetn), .addr(bus.addr),
    .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .rvalid(bus.rvalid),
    .mode_q(mode_q), .busy_q(busy_q), .done_q(done_q),
    .result_q(result_q), .sum_extension_q(sum_extension_q));
  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One APB transfer; ready and read data taken at the rising edge
  // Only the watchdog ends a wait for ready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready_q !== 1'b1);
    r = prdata_q;
    perr = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Launches refused while busy, so poll status first
  task automatic idle();
    do apb(1'b0, `MMA_APB_STAT, 32'h0, rv);
    while (rv[0] !== 1'b0);
  endtask
  task automatic dev(input logic w, b, input logic [15:0] a, d);
    idle();
    apb(1'b1, `MMA_APB_ADDR, {16'h0, a}, rv);
    apb(1'b1, `MMA_APB_WDATA, {16'h0, d}, rv);
    apb(1'b1, `MMA_APB_CTRL, {30'h0, b, w}, rv);
    idle();
    if (!w) apb(1'b0, `MMA_APB_RDATA, 32'h0, rv);
  endtask
  function automatic logic [47:0] calc(input logic [1:0] m,
    input logic [15:0] a, b, input logic [31:0] c);
    logic [31:0] p;
    logic [32:0] s;
    if (m[0]) p = $signed(a) * $signed(b);
    else p = a * b;
    s = m[1] ? {1'b0, c} + p : {1'b0, p};
    if (m[0]) return {{16{s[31]}}, s[31:0]};
    return {15'h0, s[32], s[31:0]};
  endfunction
  task automatic setacc(input logic [31:0] v);
    dev(1'b1, 1'b0, `MMA_A_RES_LO, v[15:0]);
    dev(1'b1, 1'b0, `MMA_A_RES_HI, v[31:16]);
    acc = v;
  endtask
  task automatic op(input logic [1:0] m, input logic [15:0] a, b,
    input logic ab, bb, sk);
    logic [47:0] e;
    if (!sk) begin
      dev(1'b1, ab, 16'h0130 + {m, 1'b0}, a);
      md = m;
      o1 = ab ? {8'h00, a[7:0]} : a;
    end
    dev(1'b1, bb, `MMA_A_OP2, b);
    check({30'h0, state_q}, 32'h0);
    e = calc(md, o1, bb ? {8'h00, b[7:0]} : b, acc);
    acc = e[31:0];
    ex = e[47:32];
    check(result_q, e[31:0]);
    dev(1'b0, 1'b0, `MMA_A_RES_LO, 16'h0);
    check(rv, {16'h0, e[15:0]});
    dev(1'b0, 1'b0, `MMA_A_RES_HI, 16'h0);
    check(rv, {16'h0, e[31:16]});
    dev(1'b0, 1'b0, `MMA_A_SUM_EXTENSION, 16'h0);
    check(rv, {16'h0, ex});
    dev(1'b0, 1'b0, 16'h0130 + {~md, 1'b0}, 16'h0);
    check(rv, {16'h0, o1});
  endtask
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    logic [31:0] x, y, z;
    logic [1:0] m;
    x = $urandom(72);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    setacc(32'hFFFF_FFFF);
    op(2'h2, 16'hFFFF, 16'hFFFF, 1'b0, 1'b0, 1'b0);
    setacc(32'h7FFF_FFFF);
    op(2'h3, 16'h0001, 16'h0001, 1'b0, 1'b0, 1'b0);
    setacc(32'h8000_0000);
    op(2'h3, 16'hFFFF, 16'h0001, 1'b0, 1'b0, 1'b0);
    op(2'h3, 16'h0, 16'h0002, 1'b0, 1'b0, 1'b1);
    op(2'h1, 16'h80FF, 16'hFF80, 1'b1, 1'b0, 1'b0);
    dev(1'b1, 1'b0, `MMA_A_SUM_EXTENSION, 16'h1234);
    dev(1'b0, 1'b0, `MMA_A_SUM_EXTENSION, 16'h0);
    check(rv, {16'h0, ex});
    dev(1'b0, 1'b0, 16'h0140, 16'h0);
    check(rv, 32'h0);
    apb(1'b0, 8'h14, 32'h0, rv);
    check({31'h0, perr}, 32'h1);
    repeat (30) begin
      x = $urandom;
      y = $urandom;
      z = $urandom;
      m = (x[5:4] == 2'h0) ? md : x[1:0];
      // Signed modes: bytes are widened here, as software must
      if (m[0] && x[2]) y[15:8] = {8{y[7]}};
      if (m[0] && x[3]) z[15:8] = {8{z[7]}};
      op(x[1:0], y[15:0], z[15:0], x[2] && !m[0], x[3] && !m[0],
        x[5:4] == 2'h0);
    end
    final_report();
  end
endmodule
